// ==== rtl/sdc_pkg.sv ====
/*
  shared constants and carrier types of the synthesizer divider and configuration logic.
  assumes a single 40 MHz ref_clk domain; every configuration pin arrives asynchronous to it, the wishbone pins are on ref_clk.
*/
package sdc_pkg;

  // field widths
  localparam int SDC_M_W = 7;
  localparam int SDC_N_W = 2;
  localparam int SDC_T_W = 3;
  localparam int SDC_SR_W = 12;
  localparam int SDC_DIV_W = 8;
  localparam int SDC_STEP_W = 3;

  // power-down stepping: four halvings reach one sixteenth
  localparam logic [SDC_STEP_W-1:0] SDC_STEP_MAX = 3'h4;

  // serial word layout, most significant field shifted first
  localparam int SDC_SR_T_LSB = 9;
  localparam int SDC_SR_N_LSB = 7;
  localparam int SDC_SR_M_LSB = 0;

  // register byte offsets
  localparam logic [3:0] SDC_OFS_CTRL = 4'h0;
  localparam logic [3:0] SDC_OFS_STATUS = 4'h4;

  // status word field positions
  localparam int SDC_ST_M_LSB = 0;
  localparam int SDC_ST_N_LSB = 7;
  localparam int SDC_ST_T_LSB = 9;
  localparam int SDC_ST_STEP_LSB = 12;
  localparam int SDC_ST_RATIO_LSB = 16;

  // post-divider half-period ratios per code
  localparam logic [SDC_DIV_W-1:0] SDC_RATIO_C0 = 8'h02;
  localparam logic [SDC_DIV_W-1:0] SDC_RATIO_C1 = 8'h04;
  localparam logic [SDC_DIV_W-1:0] SDC_RATIO_C2 = 8'h08;
  localparam logic [SDC_DIV_W-1:0] SDC_RATIO_C3 = 8'h01;

  // diagnostic selections
  typedef enum logic [2:0] {
    SDC_TST_QUIET = 3'b000,
    SDC_TST_REF = 3'b001,
    SDC_TST_OUT = 3'b010,
    SDC_TST_SHIFT = 3'b011,
    SDC_TST_SLOW = 3'b100,
    SDC_TST_PLOAD = 3'b101,
    SDC_TST_SLOAD = 3'b110,
    SDC_TST_HIGH = 3'b111
  } sdc_test_e;

  // configuration pins as one bundle
  typedef struct packed {
    logic [SDC_M_W-1:0] m;
    logic [SDC_N_W-1:0] n;
    logic pLoad;
    logic sClk;
    logic sData;
    logic sLoad;
    logic slowReq;
    logic refSel;
    logic oe;
    logic xtalClk;
    logic altRef;
  } sdc_pins_s;

  // active divider configuration
  typedef struct packed {
    logic [SDC_T_W-1:0] t;
    logic [SDC_N_W-1:0] n;
    logic [SDC_M_W-1:0] m;
  } sdc_cfg_s;

  // whole state of the block
  typedef struct packed {
    sdc_pins_s sync1;
    sdc_pins_s sync2;
    sdc_pins_s prev;
    logic [SDC_SR_W-1:0] shiftReg;
    sdc_cfg_s cfg;
    logic [SDC_STEP_W-1:0] step;
    logic swSlow;
    logic [SDC_DIV_W-1:0] divCnt;
    logic tog;
    logic oeOn;
    logic fOut;
    logic fOutN;
    logic testOut;
    logic ack;
    logic [31:0] rdat;
  } sdc_state_s;

  // undriven pins read as pulled: m, n, parallel load and ref select high; serial load low
  localparam sdc_pins_s SDC_PINS_RST = '{m: 7'h7f, n: 2'h3, pLoad: 1'b1, sClk: 1'b0, sData: 1'b0,
    sLoad: 1'b0, slowReq: 1'b0, refSel: 1'b1, oe: 1'b0, xtalClk: 1'b0, altRef: 1'b0};
  localparam sdc_cfg_s SDC_CFG_RST = '{t: 3'h0, n: 2'h3, m: 7'h7f};
  localparam sdc_state_s SDC_STATE_RST = '{sync1: SDC_PINS_RST, sync2: SDC_PINS_RST, prev: SDC_PINS_RST,
    shiftReg: 12'h000, cfg: SDC_CFG_RST, step: 3'h0, swSlow: 1'b0, divCnt: 8'h00, tog: 1'b0,
    oeOn: 1'b0, fOut: 1'b0, fOutN: 1'b1, testOut: 1'b0, ack: 1'b0, rdat: 32'h0000_0000};

endpackage

// ==== rtl/sdc_synth_cfg.sv ====
/*
  divider configuration logic of a pll clock synthesizer: parallel and 3-wire serial loading,
  power-down frequency stepping, post-divider, output enable, diagnostic output, wishbone slave.
  assumes all configuration pins and both reference clocks are asynchronous to ref_clk;
  the divided output is a model at ref_clk rate, one ref_clk cycle per ratio count, ratio counts per half period.
  the bus side is classic wishbone on ref_clk; every request is answered one cycle later.
  pull-ups are modelled as synchroniser reset values; no analogue loop is modelled here.
  pin levels must outlast two ref_clk edges to be seen at all.
  both reference clocks must run well below ref_clk, since they are sampled.
*/
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps

// What this block does
// [R1] parallel m and n inputs set dividers
// [R2] parallel inputs captured on load rising
// [R3] parallel latch transparent while load low
// [R4] parallel load overrides serial load
// [R5] controller keeps parallel load low at reset
// [R6] undriven parallel inputs read as one
// [R7] twelve-bit shifter advances on serial clock rise
// [R8] serial latch captures on load falling
// [R9] serial latch transparent while load high
// [R10] three serial bits select diagnostic output
// [R11] controller keeps diagnostic output quiet normally
// [R12] power-down divides output frequency by sixteen
// [R13] power-down steps timed by reference clock
// [R14] four discrete steps each way
// [R15] post-divider 1,2,4,8 with even duty
// [R16] feedback value sets loop multiplier
// [R17] reference select picks pll reference source
// [R18] code 00/01/10/11 gives 2/4/8/1
// [R19] output enable synchronous, stops output low
// [R20] select zero external, one crystal
// [R21] serial word: test, post, feedback fields
// [R22] each step doubles divide on reference edge
module sdc_synth_cfg
  import sdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [SDC_M_W-1:0] parM,
  input wire logic [SDC_N_W-1:0] parN,
  input wire logic parLoad,
  input wire logic serClk,
  input wire logic serData,
  input wire logic serLoad,
  input wire logic slow_by_sixteen_req,
  input wire logic ref_source_select,
  input wire logic outEnable,
  input wire logic xtalClk,
  input wire logic alt_ref_in,
  output logic fOut,
  output logic fOutN,
  output logic testOut,
  output logic [SDC_M_W-1:0] pllMult,
  output logic [SDC_N_W-1:0] postDivCode,
  output logic refIsXtal,
  output logic [SDC_STEP_W-1:0] slowStep,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  sdc_state_s st_r;
  sdc_state_s st_nxt;
  sdc_pins_s pinsNow;
  logic [SDC_DIV_W-1:0] baseRatio;
  logic [SDC_DIV_W-1:0] ratio;
  logic refNow;
  logic refPrev;
  logic refRise;
  logic slowWanted;
  logic busReq;
  logic stepUp;
  logic stepDown;
  logic divWrap;
  logic [31:0] ctrlWord;
  logic [31:0] statusWord;

  // pin bundle entering the first synchroniser stage
  // every pin here is asynchronous to ref_clk
  always_comb
  begin
    pinsNow.m = parM;
    pinsNow.n = parN;
    pinsNow.pLoad = parLoad;
    pinsNow.sClk = serClk;
    pinsNow.sData = serData;
    pinsNow.sLoad = serLoad;
    pinsNow.slowReq = slow_by_sixteen_req;
    pinsNow.refSel = ref_source_select;
    pinsNow.oe = outEnable;
    pinsNow.xtalClk = xtalClk;
    pinsNow.altRef = alt_ref_in;
  end

  // reference choice and its edge, read only from the second stage
  // both references are sampled, so they must run well below ref_clk
  assign refNow = st_r.sync2.refSel ? st_r.sync2.xtalClk : st_r.sync2.altRef; // [R17] [R20]
  assign refPrev = st_r.prev.refSel ? st_r.prev.xtalClk : st_r.prev.altRef;
  assign refRise = refNow & ~refPrev;
  assign slowWanted = st_r.sync2.slowReq | st_r.swSlow;
  assign busReq = wb_cyc_i & wb_stb_i & ~st_r.ack;

  // power-down direction, one step per reference rising edge
  // the walk stops at either end, so a held request parks at one sixteenth
  // and a released one parks at the programmed frequency
  assign stepUp = slowWanted && (st_r.step != SDC_STEP_MAX); // [R14]
  assign stepDown = !slowWanted && (st_r.step != 3'h0); // [R14]

  // divider wrap point; a half period spans ratio counts
  // ratio never drops below one, so the subtraction cannot wrap
  assign divWrap = (st_r.divCnt >= ratio - 8'h01); // [R15]

  // post-divider code to half-period ratio, doubled per slow step
  always_comb
  begin
    // ratios count ref_clk cycles per half period
    // step shifts by at most four, so 128 is the largest ratio
    case (st_r.cfg.n) // [R18]
      2'b00:
      begin
        baseRatio = SDC_RATIO_C0; // divide by two
      end
      2'b01:
      begin
        baseRatio = SDC_RATIO_C1; // divide by four
      end
      2'b10:
      begin
        baseRatio = SDC_RATIO_C2; // divide by eight
      end
      2'b11:
      begin
        baseRatio = SDC_RATIO_C3; // straight through
      end
      default:
      begin
        baseRatio = SDC_RATIO_C3;
      end
    endcase
    ratio = SDC_DIV_W'(baseRatio << st_r.step); // [R12] [R22]
  end

  // readback words, kept apart from the bus decode
  // status mirrors the active settings, not the pins, so software
  // sees exactly what drives the divider
  // unused bits read zero
  always_comb
  begin
    ctrlWord = 32'h0000_0000;
    ctrlWord[0] = st_r.swSlow;
    statusWord = 32'h0000_0000;
    statusWord[SDC_ST_M_LSB +: SDC_M_W] = st_r.cfg.m;
    statusWord[SDC_ST_N_LSB +: SDC_N_W] = st_r.cfg.n;
    statusWord[SDC_ST_T_LSB +: SDC_T_W] = st_r.cfg.t;
    statusWord[SDC_ST_STEP_LSB +: SDC_STEP_W] = st_r.step;
    statusWord[SDC_ST_RATIO_LSB +: SDC_DIV_W] = ratio;
  end

  // next state of the whole block
  always_comb
  begin
    st_nxt = st_r;
    // two-stage synchronisers, then history for edge finding
    // only the second stage feeds logic; the first may be metastable
    // prev holds the second stage one cycle late, for edge compares
    st_nxt.sync1 = pinsNow;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;

    // serial shifter, msb field first
    // a 200 ns serial clock gives four samples per phase, so no edge is lost
    // extra bits push the oldest out of the top
    if (st_r.sync2.sClk && !st_r.prev.sClk) // [R7] [R21]
    begin
      st_nxt.shiftReg = {st_r.shiftReg[SDC_SR_W-2:0], st_r.sync2.sData};
    end

    // configuration latches: parallel transparent while low, wins over serial
    // both loads are level sensitive: the last value seen before the
    // closing edge stays, which is what the capture edges amount to
    // the serial side never touches the settings while parallel is open
    // the diagnostic field only ever comes from the serial word
    if (!st_r.sync2.pLoad) // [R1] [R2] [R3] [R4] [R6]
    begin
      st_nxt.cfg.m = st_r.sync2.m;
      st_nxt.cfg.n = st_r.sync2.n;
    end
    else if (st_r.sync2.sLoad) // [R8] [R9]
    begin
      st_nxt.cfg.t = st_r.shiftReg[SDC_SR_T_LSB +: SDC_T_W]; // [R10] [R21]
      st_nxt.cfg.n = st_r.shiftReg[SDC_SR_N_LSB +: SDC_N_W];
      st_nxt.cfg.m = st_r.shiftReg[SDC_SR_M_LSB +: SDC_M_W];
    end

    // power-down walks one halving per reference edge
    // changing reference select may add one extra edge; harmless
    // the slow pace keeps the loop from seeing a sudden jump
    if (refRise) // [R13] [R14] [R22]
    begin
      if (stepUp)
      begin
        st_nxt.step = st_r.step + 3'h1;
      end
      else if (stepDown)
      begin
        st_nxt.step = st_r.step - 3'h1;
      end
    end

    // post-divider: toggle each ratio counts, even duty
    // counter restarts when a slow step shortens the ratio mid count
    // high and low halves are equal in length while the ratio holds still
    if (divWrap) // [R15]
    begin
      st_nxt.divCnt = 8'h00;
      st_nxt.tog = ~st_r.tog;
    end
    else
    begin
      st_nxt.divCnt = st_r.divCnt + 8'h01;
    end

    // enable changes only while output sits low, so no runt pulse
    // oeOn is sampled against the next toggle value so an enable change
    // never cuts a high half short
    if (!st_nxt.tog) // [R19]
    begin
      st_nxt.oeOn = st_r.sync2.oe;
    end
    st_nxt.fOut = st_nxt.tog & st_nxt.oeOn; // [R19]
    st_nxt.fOutN = ~(st_nxt.tog & st_nxt.oeOn);

    // diagnostic output selection
    // selection 0 keeps the pin still for low jitter
    // toggling selections are for bring-up only
    case (sdc_test_e'(st_r.cfg.t)) // [R10]
      SDC_TST_QUIET:
      begin
        st_nxt.testOut = 1'b0;
      end
      SDC_TST_REF:
      begin
        st_nxt.testOut = refNow;
      end
      SDC_TST_OUT:
      begin
        st_nxt.testOut = st_r.tog;
      end
      SDC_TST_SHIFT:
      begin
        st_nxt.testOut = st_r.shiftReg[SDC_SR_W-1];
      end
      SDC_TST_SLOW:
      begin
        st_nxt.testOut = (st_r.step != 3'h0);
      end
      SDC_TST_PLOAD:
      begin
        st_nxt.testOut = st_r.sync2.pLoad;
      end
      SDC_TST_SLOAD:
      begin
        st_nxt.testOut = st_r.sync2.sLoad;
      end
      SDC_TST_HIGH:
      begin
        st_nxt.testOut = 1'b1;
      end
      default:
      begin
        st_nxt.testOut = 1'b0;
      end
    endcase

    // wishbone classic slave, one wait-free ack per request
    // ack is blocked for one cycle after it is given, so a held strobe
    // is answered every second cycle, never on two cycles in a row
    // writes land at the taking edge, the same edge that raises the ack
    st_nxt.ack = busReq;
    if (busReq)
    begin
      st_nxt.rdat = 32'h0000_0000;
      case (wb_adr_i)
        SDC_OFS_CTRL:
        begin
          if (wb_we_i && wb_sel_i[0])
          begin
            st_nxt.swSlow = wb_dat_i[0];
          end
          st_nxt.rdat = ctrlWord;
        end
        SDC_OFS_STATUS:
        begin
          st_nxt.rdat = statusWord;
        end
        default:
        begin
          st_nxt.rdat = 32'h0000_0000; // unmapped reads zero
        end
      endcase
    end
  end

  // state register
  // synchronous reset only; the pin stages reset to the pulled levels
  // so nothing appears to change when reset lets go
  // one reset edge loads every synchroniser stage completely
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      st_r <= SDC_STATE_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state
  // every output is a flip-flop, none passes through logic
  // so the pins never glitch between edges
  assign fOut = st_r.fOut;
  assign fOutN = st_r.fOutN;
  assign testOut = st_r.testOut;
  assign pllMult = st_r.cfg.m; // [R16]
  assign postDivCode = st_r.cfg.n;
  assign refIsXtal = st_r.sync2.refSel; // [R17]
  assign slowStep = st_r.step;
  assign wb_dat_o = st_r.rdat;
  assign wb_ack_o = st_r.ack;

endmodule // sdc_synth_cfg

// ==== sim/sdc_ser_host.sv ====
/* serial host model: shifts a 12-bit word msb first, then pulses load.
   assumes ref_clk paces it; serial clock 200 ns, idle low between frames. */
`timescale 1ns/10ps
module sdc_ser_host
  import sdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [SDC_SR_W-1:0] word,
  output logic serClk,
  output logic serData,
  output logic serLoad,
  output logic busy
);
  initial {serClk, serData, serLoad, busy} = 4'h0;
  // one frame per go, four ref_clk cycles a phase
  always @(posedge ref_clk)
    if (go && !busy)
    begin
      busy <= 1'b1;
      for (int i = SDC_SR_W - 1; i >= 0; i--)
      begin
        serData <= word[i];
        repeat (4) @(posedge ref_clk);
        serClk <= 1'b1;
        repeat (4) @(posedge ref_clk);
        serClk <= 1'b0;
      end
      serLoad <= 1'b1;
      repeat (4) @(posedge ref_clk);
      {serLoad, serData} <= {1'b0, ~word[0]};
      busy <= 1'b0;
    end
endmodule // sdc_ser_host

// ==== sim/sdc_synth_cfg_checker.sv ====
/* port assertions of sdc_synth_cfg.
   assumes one ref_clk domain with synchronous active-high rst. */
`timescale 1ns/10ps
module sdc_synth_cfg_checker
  import sdc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [6:0] parM,
  input wire logic parLoad,
  input wire logic ref_source_select,
  input wire logic fOut,
  input wire logic fOutN,
  input wire logic [6:0] pllMult,
  input wire logic refIsXtal,
  input wire logic [2:0] slowStep,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  // one domain, quiet in reset
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  a_out_pair: assert property (fOutN == !fOut)
    else $error("outputs not paired");
  a_step_max: assert property (slowStep <= SDC_STEP_MAX)
    else $error("step overrun");
  a_step_single: assert property ($changed(slowStep) |-> slowStep - $past(slowStep) == 3'h1
    || $past(slowStep) - slowStep == 3'h1) else $error("step jump");
  a_ref_follow: assert property ($stable(ref_source_select) [*5] |-> refIsXtal == ref_source_select)
    else $error("ref select lost");
  a_par_track: assert property ((!parLoad && $stable(parM)) [*7] |-> pllMult == parM)
    else $error("parallel not passed");
  // main scenarios reached
  c_slow: cover property (slowStep == SDC_STEP_MAX);
  c_ack: cover property (wb_ack_o);
  c_par_open: cover property (!parLoad [*7]);
endmodule // sdc_synth_cfg_checker

// watch the synthesizer top
bind sdc_synth_cfg sdc_synth_cfg_checker chk (.ref_clk, .rst, .parM, .parLoad, .ref_source_select, .fOut,
  .fOutN, .pllMult, .refIsXtal, .slowStep, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// ==== sim/tb_sdc_synth_cfg.sv ====
/* bench for sdc_synth_cfg: pins, serial host, wishbone, power-down.
   assumes 40 MHz ref_clk; both references run at 5 MHz. */
`timescale 1ns/10ps
module tb_sdc_synth_cfg
  import sdc_pkg::*;
;
  logic ref_clk = 0, rst = 1, parLoad = 0, slow_by_sixteen_req = 0, ref_source_select = 1, outEnable = 1;
  logic xtalClk = 0, alt_ref_in = 0, go = 0, busy, serClk, serData, serLoad, fOut, fOutN, testOut;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, refIsXtal;
  logic [6:0] parM = 7'h7f, pllMult;
  logic [1:0] parN = 2'h3, postDivCode;
  logic [2:0] slowStep;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [11:0] word = 12'h000;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  int mismatches = 0, nTests = 0, cycles = 0;
  localparam int REF_CYC = 8; // both references toggle every four cycles

  sdc_synth_cfg dut (.ref_clk, .rst, .parM, .parN, .parLoad, .serClk, .serData, .serLoad, .slow_by_sixteen_req,
    .ref_source_select, .outEnable, .xtalClk, .alt_ref_in, .fOut, .fOutN, .testOut, .pllMult, .postDivCode,
    .refIsXtal, .slowStep, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
  sdc_ser_host host (.ref_clk, .go, .word, .serClk, .serData, .serLoad, .busy);

  always #12.5 ref_clk = ~ref_clk;
  // references and hang guard
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles % 4 == 3)
      xtalClk <= ~xtalClk;
    if (cycles % 4 == 1)
      alt_ref_in <= ~alt_ref_in;
    if (cycles == 9000)
    begin
      mismatches++;
      testDone();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one classic cycle, read data left in q
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge ref_clk); while (wb_ack_o !== 1'b1 && ++k < 9);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    chk("ack", k < 9, 1);
    @(posedge ref_clk);
  endtask

  task automatic ser(input logic [11:0] w);
    int k;
    {go, word} <= {1'b1, w};
    repeat (2) @(posedge ref_clk);
    go <= 1'b0;
    for (k = 0; k < 300 && busy !== 1'b0; k++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
  endtask

  // pace counted from the first step seen, one reference period per step
  task automatic waitStep(input logic [2:0] s);
    int k;
    logic [2:0] s0;
    s0 = slowStep;
    for (k = 0; k < 200 && slowStep === s0; k++) @(posedge ref_clk);
    s0 = slowStep;
    for (k = 0; k < 200 && slowStep !== s; k++) @(posedge ref_clk);
    chk("step", slowStep, s);
    chk("pace", k, REF_CYC * ((s > s0) ? s - s0 : s0 - s));
  endtask

  // high and low halves of fOut
  task automatic half(input logic [7:0] r);
    int k;
    for (k = 0; k < 600 && fOut !== 1'b0; k++) @(posedge ref_clk);
    for (k = 0; k < 600 && fOut !== 1'b1; k++) @(posedge ref_clk);
    for (k = 0; k < 600 && fOut === 1'b1; k++) @(posedge ref_clk);
    chk("high", k, r);
    for (k = 0; k < 600 && fOut === 1'b0; k++) @(posedge ref_clk);
    chk("low", k, r);
  endtask

  task automatic regs();
    wb(1, 4'h0, 32'h1);
    waitStep(3'h4);
    wb(0, 4'h0, 32'h0);
    chk("ctrl", q, 32'h1);
    wb(1, 4'hc, 32'h0);
    wb(0, 4'hc, 32'h0);
    chk("hole", q, 32'h0);
    wb(1, 4'h0, 32'h0);
    waitStep(3'h0);
  endtask

  task automatic serial();
    ser({3'h7, 2'h1, 7'h2a});
    chk("mult", pllMult, 7'h2a);
    chk("code", postDivCode, 2'h1);
    chk("test", testOut, 1);
    wb(0, 4'h4, 0);
    chk("status", q, {8'h0, SDC_RATIO_C1, 4'h0, 3'h7, 2'h1, 7'h2a});
    half(SDC_RATIO_C1);
    ser({3'h5, 2'h3, 7'h55});
    chk("test", testOut, 1);
    ser({3'h0, 2'h3, 7'h55});
    chk("test", testOut, 0);
    half(SDC_RATIO_C3);
  endtask

  task automatic parallel();
    {parLoad, parM, parN} <= {1'b0, 7'h15, 2'h2};
    ser({3'h0, 2'h1, 7'h33});
    chk("mult", pllMult, 7'h15);
    chk("code", postDivCode, 2'h2);
    parLoad <= 1'b1;
    repeat (4) @(posedge ref_clk);
    {parM, parN} <= {7'h0c, 2'h0};
    repeat (6) @(posedge ref_clk);
    chk("held", pllMult, 7'h15);
  endtask

  task automatic slow();
    ref_source_select <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk("xtal", refIsXtal, 0);
    slow_by_sixteen_req <= 1'b1;
    waitStep(3'h4);
    wb(0, 4'h4, 0);
    chk("ratio", q[23:16], SDC_RATIO_C2 << 4);
    half(SDC_RATIO_C2 << 4);
    slow_by_sixteen_req <= 1'b0;
    waitStep(3'h0);
    ref_source_select <= 1'b1;
  endtask

  task automatic oe();
    outEnable <= 1'b0;
    repeat (40) @(posedge ref_clk);
    chk("off", {fOut, fOutN}, 2'b01);
    outEnable <= 1'b1;
    half(SDC_RATIO_C2);
  endtask

  task automatic testDone();
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // load strobe low through reset, then the scenarios
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk("mult", pllMult, 7'h7f);
    chk("code", postDivCode, 2'h3);
    chk("xtal", refIsXtal, 1);
    parLoad <= 1'b1;
    regs();
    serial();
    parallel();
    slow();
    oe();
    testDone();
  end
endmodule // tb_sdc_synth_cfg
